//--- sro_ctrl.sv
/*
 * sro_ctrl: supply rail or'ing controller top. Start-up sequencer, parallel
 * limb switches, charge pump gate toggle, negative two-rail or'ing and feed
 * failure outputs, with a small register port and one interrupt line.
 * Assumes comparator outputs and load-on indication are asynchronous levels,
 * and the register master is on clk_i.
 */
// The placing of the registers and the address-and-strobe port were left to the implementer.
// Behaviour
// - after reset switches off, await valid rail
// - enable load, then await load on
// - limb switch on above turn-on current
// - limb switch off below turn-off current
// - running limbs re-arm and monitor until run state is left
// - every limb decided in parallel logic
// - two comparators per limb give hysteresis
// - rail valid from window comparator pair
// - gate drive toggles 32us high, 8us low
// - higher rail on, other rail off
// - inside dead band both switches on
// - negative switches start off
// - per-feed failure on low voltage
`timescale 1ns/1ps
module sro_ctrl
	import sro_pkg::*;
#(
	parameter int PUMP_HIGH_CYCLES = sro_pkg::PUMP_HIGH_CYC,
	parameter int PUMP_LOW_CYCLES = sro_pkg::PUMP_LOW_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// register port
	input wire logic [sro_pkg::ADDR_W-1:0] addr_i,
	input wire logic [sro_pkg::DATA_W-1:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [sro_pkg::DATA_W-1:0] rd_data_o,
	output logic irq_o,
	// rail window comparators and load status
	input wire logic [sro_pkg::N_LIMBS-1:0] rail_above_min_i,
	input wire logic [sro_pkg::N_LIMBS-1:0] rail_below_max_i,
	input wire logic load_on_i,
	output logic load_en_o,
	// limb current comparators and switches
	input wire logic [sro_pkg::N_LIMBS-1:0] limb_above_on_i,
	input wire logic [sro_pkg::N_LIMBS-1:0] limb_above_off_i,
	output logic [sro_pkg::N_LIMBS-1:0] limb_sw_o,
	// charge pump
	output logic gate_drive_out_o,
	// negative two-rail or'ing
	input wire logic rail_a_higher_i,
	input wire logic rail_b_higher_i,
	input wire logic feed_a_low_i,
	input wire logic feed_b_low_i,
	output logic neg_sw_a_o,
	output logic neg_sw_b_o,
	output logic feed_a_fail_o,
	output logic feed_b_fail_o
);

	import sro_pkg::*;

	localparam int SYNC_W = 4 * N_LIMBS + 5;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	logic [SYNC_W-1:0] sync_s;
	logic [N_LIMBS-1:0] rail_min_s;
	logic [N_LIMBS-1:0] rail_max_s;
	logic [N_LIMBS-1:0] above_on_s;
	logic [N_LIMBS-1:0] above_off_s;
	logic load_on_s;
	logic a_higher_s;
	logic b_higher_s;
	logic a_low_s;
	logic b_low_s;

	sro_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.async_i({rail_above_min_i, rail_below_max_i, limb_above_on_i, limb_above_off_i,
			load_on_i, rail_a_higher_i, rail_b_higher_i, feed_a_low_i, feed_b_low_i}),
		.sync_o(sync_s)
	);

	assign {rail_min_s, rail_max_s, above_on_s, above_off_s,
		load_on_s, a_higher_s, b_higher_s, a_low_s, b_low_s} = sync_s;

	////////////////////////////////////////////////////////////////////////
	// start-up sequencer

	sro_state_t state_q;
	sro_state_t state_d;
	logic [CTRL_W-1:0] ctrl_q;
	logic rail_ok;
	logic run;

	assign rail_ok = |(rail_min_s & rail_max_s);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SRO_WAIT_RAIL: begin
				if (rail_ok && ctrl_q[CTRL_RUN_BIT]) begin
					state_d = SRO_WAIT_LOAD;
				end
			end
			SRO_WAIT_LOAD: begin
				if (!rail_ok || !ctrl_q[CTRL_RUN_BIT]) begin
					state_d = SRO_WAIT_RAIL;
				end else if (load_on_s) begin
					state_d = SRO_RUN;
				end
			end
			SRO_RUN: begin
				if (!rail_ok || !ctrl_q[CTRL_RUN_BIT]) begin
					state_d = SRO_WAIT_RAIL;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= SRO_WAIT_RAIL;
		end else if (ce_i) begin
			state_q <= state_d;
		end
	end

	assign load_en_o = (state_q != SRO_WAIT_RAIL);
	assign run = (state_q == SRO_RUN);

	////////////////////////////////////////////////////////////////////////
	// limb switches

	for (genvar g = 0; g < N_LIMBS; g++) begin : g_limb
		sro_limb u_limb (
			.clk_i(clk_i),
			.reset_i(reset_i),
			.ce_i(ce_i),
			.run_i(run),
			.above_on_i(above_on_s[g]),
			.above_off_i(above_off_s[g]),
			.sw_o(limb_sw_o[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// charge pump gate drive

	logic [PUMP_CNT_W-1:0] pump_cnt_q;
	logic [PUMP_CNT_W-1:0] pump_cnt_d;
	logic pump_q;
	logic pump_d;

	always_comb begin
		pump_cnt_d = pump_cnt_q + 16'h0001;
		pump_d = pump_q;
		if (!ctrl_q[CTRL_PUMP_BIT]) begin
			pump_cnt_d = '0;
			pump_d = 1'b0;
		end else if (pump_q && pump_cnt_q >= PUMP_CNT_W'(PUMP_HIGH_CYCLES - 1)) begin
			pump_cnt_d = '0;
			pump_d = 1'b0;
		end else if (!pump_q && pump_cnt_q >= PUMP_CNT_W'(PUMP_LOW_CYCLES - 1)) begin
			pump_cnt_d = '0;
			pump_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pump_cnt_q <= '0;
			pump_q <= 1'b0;
		end else if (ce_i) begin
			pump_cnt_q <= pump_cnt_d;
			pump_q <= pump_d;
		end
	end

	assign gate_drive_out_o = pump_q;

	////////////////////////////////////////////////////////////////////////
	// negative two-rail or'ing and feed monitors

	logic neg_a_q;
	logic neg_a_d;
	logic neg_b_q;
	logic neg_b_d;
	logic fail_a_q;
	logic fail_a_d;
	logic fail_b_q;
	logic fail_b_d;

	always_comb begin
		neg_a_d = 1'b0;
		neg_b_d = 1'b0;
		if (ctrl_q[CTRL_NEG_BIT]) begin
			if (a_higher_s && !b_higher_s) begin
				neg_a_d = 1'b1;
			end else if (b_higher_s && !a_higher_s) begin
				neg_b_d = 1'b1;
			end else if (!a_higher_s && !b_higher_s) begin
				neg_a_d = 1'b1;
				neg_b_d = 1'b1;
			end
			// both asserted is nonsense: leave body diodes to carry the load
		end
		fail_a_d = a_low_s;
		fail_b_d = b_low_s;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			neg_a_q <= 1'b0;
			neg_b_q <= 1'b0;
			fail_a_q <= 1'b0;
			fail_b_q <= 1'b0;
		end else if (ce_i) begin
			neg_a_q <= neg_a_d;
			neg_b_q <= neg_b_d;
			fail_a_q <= fail_a_d;
			fail_b_q <= fail_b_d;
		end
	end

	assign neg_sw_a_o = neg_a_q;
	assign neg_sw_b_o = neg_b_q;
	assign feed_a_fail_o = fail_a_q;
	assign feed_b_fail_o = fail_b_q;

	////////////////////////////////////////////////////////////////////////
	// registers and interrupt

	logic [CTRL_W-1:0] ctrl_d;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_stat_d;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_mask_d;
	logic [IRQ_W-1:0] irq_evt;
	logic [N_LIMBS-1:0] limb_prev_q;
	logic run_prev_q;
	logic [DATA_W-1:0] rd_data_q;
	logic [DATA_W-1:0] rd_data_d;
	logic [DATA_W-1:0] status_word;

	assign status_word = {{(DATA_W - STAT_LIMB_LSB - N_LIMBS){1'b0}}, limb_sw_o,
		pump_q, fail_b_q, fail_a_q, neg_b_q, neg_a_q, load_en_o, state_q};

	always_comb begin
		irq_evt = '0;
		irq_evt[IRQ_RUN_BIT] = run && !run_prev_q;
		// a limb opening means reverse current threatened
		irq_evt[IRQ_LIMB_OFF_BIT] = |(limb_prev_q & ~limb_sw_o);
		irq_evt[IRQ_FAIL_A_BIT] = fail_a_d && !fail_a_q;
		irq_evt[IRQ_FAIL_B_BIT] = fail_b_d && !fail_b_q;
		ctrl_d = ctrl_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		if (wr_i && addr_i == OFS_CTRL) begin
			ctrl_d = wr_data_i[CTRL_W-1:0];
		end
		if (wr_i && addr_i == OFS_IRQ_MASK) begin
			irq_mask_d = wr_data_i[IRQ_W-1:0];
		end
		if (wr_i && addr_i == OFS_IRQ_STAT) begin
			irq_stat_d = irq_stat_d & ~wr_data_i[IRQ_W-1:0];
		end
		// set beats a simultaneous clear
		irq_stat_d = irq_stat_d | irq_evt;
		rd_data_d = '0;
		if (rd_i) begin
			unique case (addr_i)
				OFS_CTRL: rd_data_d = {{(DATA_W - CTRL_W){1'b0}}, ctrl_q};
				OFS_STATUS: rd_data_d = status_word;
				OFS_IRQ_STAT: rd_data_d = {{(DATA_W - IRQ_W){1'b0}}, irq_stat_q};
				OFS_IRQ_MASK: rd_data_d = {{(DATA_W - IRQ_W){1'b0}}, irq_mask_q};
				default: rd_data_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_q <= CTRL_RESET;
			irq_stat_q <= IRQ_RESET;
			irq_mask_q <= IRQ_RESET;
			limb_prev_q <= '0;
			run_prev_q <= 1'b0;
			rd_data_q <= '0;
		end else if (ce_i) begin
			ctrl_q <= ctrl_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			limb_prev_q <= limb_sw_o;
			run_prev_q <= run;
			rd_data_q <= rd_data_d;
		end
	end

	assign rd_data_o = rd_data_q;
	assign irq_o = |(irq_stat_q & irq_mask_q);

endmodule : sro_ctrl

//--- sro_ctrl_monitor.sv
/* sro_ctrl_monitor: port assertions for sro_ctrl.
   Assumes ce_i high; a pin reaches a registered output three edges later. */
`timescale 1ns/1ps
module sro_chk
	import sro_pkg::*;
#(
	parameter int PUMP_HIGH_CYCLES = 8,
	parameter int PUMP_LOW_CYCLES = 2
) (
	// clock, reset, register port
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic [31:0] rd_data_o,
	// rails and limbs
	input wire logic [3:0] rail_above_min_i,
	input wire logic [3:0] rail_below_max_i,
	input wire logic load_en_o,
	input wire logic [3:0] limb_above_on_i,
	input wire logic [3:0] limb_above_off_i,
	input wire logic [3:0] limb_sw_o,
	// pump and negative rails
	input wire logic gate_drive_out_o,
	input wire logic rail_a_higher_i,
	input wire logic rail_b_higher_i,
	input wire logic feed_a_low_i,
	input wire logic feed_b_low_i,
	input wire logic neg_sw_a_o,
	input wire logic neg_sw_b_o,
	input wire logic feed_a_fail_o,
	input wire logic feed_b_fail_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic [15:0] hi_q;
	logic [15:0] lo_q;
	logic [1:0] age_q;
	logic pump_en_q;
	wire logic rail_ok = |(rail_above_min_i & rail_below_max_i);
	// lo starts high so the phase straddling reset or a pump enable is not judged
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hi_q <= 16'h0;
			lo_q <= 16'h8000;
			age_q <= 2'h0;
			pump_en_q <= CTRL_RESET[CTRL_PUMP_BIT];
		end else begin
			hi_q <= gate_drive_out_o ? hi_q + 16'h1 : 16'h0;
			lo_q <= gate_drive_out_o ? 16'h0 : pump_en_q ? lo_q + 16'h1 : 16'h8000;
			age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
			// pump enable mirrored from the register port
			if (wr_i && addr_i == OFS_CTRL) begin
				pump_en_q <= wr_data_i[CTRL_PUMP_BIT];
			end
		end
	end
	// a disable may cut a high phase short, so only enabled falls are timed
	sequence pump_fall_s;
		$fell(gate_drive_out_o) && $past(pump_en_q);
	endsequence
	sequence pump_rise_s;
		$rose(gate_drive_out_o) && !lo_q[15];
	endsequence
	pump_high_a: assert property (pump_fall_s |-> hi_q == PUMP_HIGH_CYCLES)
		else $error("gate drive high phase length wrong");
	pump_low_a: assert property (pump_rise_s |-> lo_q == PUMP_LOW_CYCLES)
		else $error("gate drive low phase length wrong");
	pump_off_a: assert property (!pump_en_q |=> !gate_drive_out_o)
		else $error("gate drive high while pump disabled");
	idle_off_a: assert property (!load_en_o && !$past(load_en_o) |-> limb_sw_o == 4'h0)
		else $error("limb switch on while idle");
	load_en_a: assert property ($rose(load_en_o) |-> $past(rail_ok, 3))
		else $error("load enabled without valid rail");
	limb_on_a: assert property ((limb_sw_o & ~$past(limb_sw_o) & ~$past(limb_above_on_i, 3)) == 4'h0)
		else $error("limb turned on without current");
	limb_off_a: assert property ((limb_sw_o & ~$past(limb_above_off_i, 3)) == 4'h0)
		else $error("limb kept on below turn-off");
	neg_a_on_a: assert property (neg_sw_a_o |-> !$past(rail_b_higher_i, 3))
		else $error("switch a on while b higher");
	neg_b_on_a: assert property (neg_sw_b_o |-> !$past(rail_a_higher_i, 3))
		else $error("switch b on while a higher");
	feed_fail_a: assert property (age_q == 2'h3 |->
		{feed_a_fail_o, feed_b_fail_o} == {$past(feed_a_low_i, 3), $past(feed_b_low_i, 3)})
		else $error("feed failure output wrong");
	rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
		else $error("read data outside read slot");
endmodule : sro_chk

bind sro_ctrl sro_chk #(
	.PUMP_HIGH_CYCLES(PUMP_HIGH_CYCLES),
	.PUMP_LOW_CYCLES(PUMP_LOW_CYCLES)
) u_chk (
	.clk_i(clk_i),
	.reset_i(reset_i),
	.rd_i(rd_i),
	.wr_i(wr_i),
	.addr_i(addr_i),
	.wr_data_i(wr_data_i),
	.rd_data_o(rd_data_o),
	.rail_above_min_i(rail_above_min_i),
	.rail_below_max_i(rail_below_max_i),
	.load_en_o(load_en_o),
	.limb_above_on_i(limb_above_on_i),
	.limb_above_off_i(limb_above_off_i),
	.limb_sw_o(limb_sw_o),
	.gate_drive_out_o(gate_drive_out_o),
	.rail_a_higher_i(rail_a_higher_i),
	.rail_b_higher_i(rail_b_higher_i),
	.feed_a_low_i(feed_a_low_i),
	.feed_b_low_i(feed_b_low_i),
	.neg_sw_a_o(neg_sw_a_o),
	.neg_sw_b_o(neg_sw_b_o),
	.feed_a_fail_o(feed_a_fail_o),
	.feed_b_fail_o(feed_b_fail_o)
);

//--- sro_limb.sv
/*
 * sro_limb: switch decision for one positive rail limb.
 * Assumes synchronised comparator levels and a run level from the sequencer.
 */
`timescale 1ns/1ps
module sro_limb (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// control
	input wire logic run_i,
	// comparators: above turn-on, above turn-off
	input wire logic above_on_i,
	input wire logic above_off_i,
	// switch
	output logic sw_o
);

	logic sw_q;
	logic sw_d;

	always_comb begin
		sw_d = sw_q;
		if (!run_i) begin
			sw_d = 1'b0;
		end else if (sw_q) begin
			if (!above_off_i) begin
				sw_d = 1'b0;
			end
		end else if (above_on_i) begin
			sw_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sw_q <= 1'b0;
		end else if (ce_i) begin
			sw_q <= sw_d;
		end
	end

	assign sw_o = sw_q;

endmodule : sro_limb

//--- sro_pkg.sv
/*
 * sro_pkg: constants shared by the supply rail or'ing controller.
 * Assumes a 200 MHz system clock and a 32-bit register port with byte addresses.
 */
package sro_pkg;

	// structure
	localparam int N_LIMBS = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// timing of the charge pump toggle
	localparam int CLK_MHZ = 200;
	localparam int PUMP_HIGH_US = 32;
	localparam int PUMP_LOW_US = 8;
	localparam int PUMP_HIGH_CYC = PUMP_HIGH_US * CLK_MHZ;
	localparam int PUMP_LOW_CYC = PUMP_LOW_US * CLK_MHZ;
	localparam int PUMP_CNT_W = 16;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;

	// control fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_NEG_BIT = 1;
	localparam int CTRL_PUMP_BIT = 2;
	localparam int CTRL_W = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h7;

	// status fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_LOAD_EN_BIT = 2;
	localparam int STAT_NEG_A_BIT = 3;
	localparam int STAT_NEG_B_BIT = 4;
	localparam int STAT_FAIL_A_BIT = 5;
	localparam int STAT_FAIL_B_BIT = 6;
	localparam int STAT_PUMP_BIT = 7;
	localparam int STAT_LIMB_LSB = 8;

	// interrupt fields
	localparam int IRQ_RUN_BIT = 0;
	localparam int IRQ_LIMB_OFF_BIT = 1;
	localparam int IRQ_FAIL_A_BIT = 2;
	localparam int IRQ_FAIL_B_BIT = 3;
	localparam int IRQ_W = 4;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	// sequencer states
	typedef enum logic [1:0] {
		SRO_WAIT_RAIL,
		SRO_WAIT_LOAD,
		SRO_RUN
	} sro_state_t;

endpackage : sro_pkg

//--- sro_plant.sv
/* sro_plant: behavioural comparators in front of the controller.
   Assumes levels in arbitrary units; outputs follow at once. */
`timescale 1ns/1ps
module sro_plant #(
	parameter int ON_TH = 20,
	parameter int OFF_TH = 10,
	parameter int V_MIN = 40,
	parameter int V_MAX = 60
) (
	// levels
	input wire logic [3:0][7:0] cur_i,
	input wire logic [3:0][7:0] volt_i,
	// comparators
	output logic [3:0] above_on_o,
	output logic [3:0] above_off_o,
	output logic [3:0] above_min_o,
	output logic [3:0] below_max_o
);
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			above_on_o[g] = cur_i[g] > ON_TH;
			above_off_o[g] = cur_i[g] > OFF_TH;
			above_min_o[g] = volt_i[g] > V_MIN;
			below_max_o[g] = volt_i[g] < V_MAX;
		end
	end
endmodule : sro_plant

//--- sro_sync.sv
/*
 * sro_sync: two-stage synchroniser for a vector of asynchronous levels.
 * Assumes inputs come from comparators or pins outside the clock domain.
 */
`timescale 1ns/1ps
module sro_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage read only by the second
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else if (ce_i) begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : sro_sync

//--- tb.sv
/* tb: random comparator levels into sro_ctrl, checked each cycle
   against a cycle model. Assumes the sro_plant thresholds. */
`timescale 1ns/1ps
module tb;
	logic clk_i, reset_i, wr, rd, load_on, ah, bh, fla, flb, ok;
	logic [7:0] addr;
	logic [31:0] wd, rd_data_o, m_rd, st_w;
	logic [3:0][7:0] cur, volt;
	logic [3:0] amin, bmax, aon, aoff, limb_sw_o, m_sw, nsw, m_stat, m_mask;
	logic load_en_o, irq_o, na_o, nb_o, fa_o, fb_o, gd, m_na, m_nb, m_fa, m_fb, m_pq;
	logic [1:0] m_st, n_st, m_dly;
	int m_pc;
	// short pump phases keep the run brief
	localparam int P_HI = 8;
	localparam int P_LO = 2;
	logic [2:0] m_ctrl;
	logic [20:0] s1, s2, x;
	logic [2:0] mode [4] = '{3'h6, 3'h5, 3'h7, 3'h3};
	int err_count = 0;
	int n_tests = 0;
	integer seed = 32'h86ee;
	wire logic [10:0] seen_v = {load_en_o, limb_sw_o, na_o, nb_o, fa_o, fb_o, irq_o, gd};
	wire logic [10:0] exp_v = {m_st != 2'h0, m_sw, m_na, m_nb, m_fa, m_fb, |(m_stat & m_mask), m_pq};

	sro_plant u_plant (.cur_i(cur), .volt_i(volt), .above_on_o(aon), .above_off_o(aoff),
		.above_min_o(amin), .below_max_o(bmax));
	sro_ctrl #(.PUMP_HIGH_CYCLES(P_HI), .PUMP_LOW_CYCLES(P_LO)) dut (.clk_i(clk_i), .reset_i(reset_i),
		.ce_i(1'b1), .addr_i(addr), .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data_o),
		.irq_o(irq_o), .rail_above_min_i(amin), .rail_below_max_i(bmax), .load_on_i(load_on),
		.load_en_o(load_en_o), .limb_above_on_i(aon), .limb_above_off_i(aoff), .limb_sw_o(limb_sw_o),
		.gate_drive_out_o(gd), .rail_a_higher_i(ah), .rail_b_higher_i(bh), .feed_a_low_i(fla),
		.feed_b_low_i(flb), .neg_sw_a_o(na_o), .neg_sw_b_o(nb_o), .feed_a_fail_o(fa_o), .feed_b_fail_o(fb_o));

	always #2.5 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= d;
		@(posedge clk_i);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	task automatic tally_and_finish();
		if (err_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////
	// cycle model: two sync stages, then registered decisions
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			{s1, s2, m_st, m_sw, m_na, m_nb, m_fa, m_fb, m_stat, m_mask, m_rd, m_dly, m_pq, m_pc} = '0;
			m_ctrl = 3'h7;
		end else begin
			st_w = {20'h0, m_sw, m_pq, m_fb, m_fa, m_nb, m_na, m_st != 2'h0, m_st};
			m_rd = !rd ? '0 : addr == 8'h00 ? {29'h0, m_ctrl} : addr == 8'h04 ? st_w
				: addr == 8'h08 ? {28'h0, m_stat} : addr == 8'h0c ? {28'h0, m_mask} : '0;
			x = s2;
			s2 = s1;
			s1 = {amin, bmax, load_on, aon, aoff, ah, bh, fla, flb};
			ok = |(x[20:17] & x[16:13]) && m_ctrl[0];
			n_st = !ok ? 2'h0 : (m_st == 2'h0 || (m_st == 2'h1 && x[12])) ? m_st + 2'h1 : m_st;
			nsw = (m_st == 2'h2) ? (m_sw | x[11:8]) & x[7:4] : 4'h0;
			// run entry and limb opening are flagged one edge after the state or switch moves
			m_stat = m_stat & ~((wr && addr == 8'h08) ? wd[3:0] : 4'h0) | {x[0] & !m_fb, x[1] & !m_fa, m_dly};
			m_dly = {|(m_sw & ~nsw), n_st == 2'h2 && m_st != 2'h2};
			m_sw = nsw;
			m_st = n_st;
			m_na = m_ctrl[1] && !x[2];
			m_nb = m_ctrl[1] && !x[3];
			m_fa = x[1];
			m_fb = x[0];
			if (!m_ctrl[2] || (m_pq ? m_pc >= P_HI - 1 : m_pc >= P_LO - 1)) begin
				m_pq = m_ctrl[2] && !m_pq;
				m_pc = 0;
			end else begin
				m_pc++;
			end
			if (wr && addr == 8'h00) m_ctrl = wd[2:0];
			if (wr && addr == 8'h0c) m_mask = wd[3:0];
		end
	end

	always @(negedge clk_i) begin
		if (!reset_i) begin
			chk({21'h0, seen_v}, {21'h0, exp_v});
			chk(rd_data_o, m_rd);
		end
	end

	initial begin
		{clk_i, wr, rd, load_on, ah, bh, fla, flb} = '0;
		{addr, wd, cur, volt} = '0;
		reset_i = 1'b1;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		bus(1'b1, 8'h10, 32'hffff_ffff);
		for (int a = 0; a < 20; a += 4) bus(1'b0, 8'(a), '0);
		volt <= {8'd0, 8'd0, 8'd70, 8'd50};
		foreach (mode[i]) begin
			bus(1'b1, 8'h00, {29'h0, mode[i]});
			repeat (100) begin
				for (int g = 0; g < 4; g++) cur[g] <= 8'($unsigned($random(seed)) % 32);
				volt[0] <= 8'(35 + $unsigned($random(seed)) % 30);
				{ah, bh, fla, flb} <= 4'($random(seed));
				load_on <= ($random(seed) & 7) != 0;
				repeat (1 + $unsigned($random(seed)) % 4) @(posedge clk_i);
			end
		end
		repeat (10) @(posedge clk_i);
		bus(1'b0, 8'h08, '0);
		bus(1'b1, 8'h0c, 32'hf);
		bus(1'b1, 8'h08, 32'hf);
		bus(1'b0, 8'h08, '0);
		bus(1'b1, 8'h0c, '0);
		tally_and_finish();
	end

	initial begin
		#20000;
		err_count++;
		tally_and_finish();
	end
endmodule : tb
